// ==== logic/pms_program_memory_security.sv ====
// Program-memory mapping, lock levels, option byte and signature access
//
// Behaviour
// - Reset selects full 16kB internal program space
// - Full size: low 16kB fetches stay internal
// - Size field written only after timed unlock
// - New size limit applies to next fetch
// - Grounded fetch pin forces non-loader fetches external, refused at level 4
// - Level 1: no lock, encrypted verify if programmed
// - Level 2: block table reads, latch pin, programming
// - Level 3: adds no verify, no SRAM moves
// - Level 4: adds no external code execution
// - Option byte is flash, byte-wide erase and program
// - Option bit 3 low enables watchdog at power-up
// - Undefined option bits read back as one
// - Option byte read at FCh or verify command
// - Signatures readable only in programming modes
// - Locations 30h, 31h, 60h return identification bytes
// - Loader programs flash, security block, SRAM
// - Loader detects host bit rate automatically
// - Loader flash access gated by lock bits
`timescale 1ns/100ps
module pms_program_memory_security
    import pms_pkg::*;
#(
    parameter logic [7:0] MAKER_ID  = 8'h5A,  // Arbitrary value
    parameter logic [7:0] DEVICE_ID = 8'h3C,  // Arbitrary value
    parameter logic [7:0] EXT_ID    = 8'h07   // Arbitrary value
)
(
    input  wire logic               core_clk,
    input  wire logic               reset_n,
    input  wire logic               reset_pin,
    input  wire logic               external_fetch_select_n,
    input  wire logic               program_store_strobe_n,
    input  wire logic               parallel_mode_pin,
    input  wire logic               serial_rx_pin,
    input  wire logic               fetch_valid,
    input  wire logic [ADDR_W-1:0]  fetch_addr,
    output logic                    fetch_internal,
    output logic                    fetch_external,
    output logic                    fetch_loader_rom,
    output logic                    fetch_refused,
    input  wire logic               table_read_valid,
    input  wire logic               table_read_from_external,
    input  wire logic [ADDR_W-1:0]  table_read_addr,
    output logic                    table_read_internal,
    output logic                    table_read_blocked,
    input  wire logic               data_move_valid,
    input  wire logic               data_move_from_external,
    input  wire logic               data_move_to_sram,
    output logic                    data_move_sram_allowed,
    output logic                    data_move_blocked,
    input  wire logic               ta_write,
    input  wire logic [7:0]         ta_wdata,
    input  wire logic               size_write,
    input  wire logic [2:0]         size_wdata,
    output logic [2:0]              program_size_select,
    input  wire logic               encryption_programmed,
    input  wire logic               prog_valid,
    input  wire logic [3:0]         prog_cmd,
    input  wire logic [7:0]         prog_addr,
    input  wire logic [7:0]         prog_wdata,
    output logic [7:0]              prog_rdata,
    output logic                    prog_done,
    output logic                    prog_refused,
    output logic                    flash_write_grant,
    output logic                    verify_grant,
    output logic                    verify_encrypted,
    output logic                    loader_mode,
    output logic                    watchdog_reset_enable,
    output logic [BAUD_W-1:0]       baud_divisor,
    output logic                    baud_locked,
    output pms_level_t              lock_level
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: reset pin, fetch select, store strobe, parallel, rx
    logic [4:0] pin_meta;
    logic [4:0] pin_sync;
    logic       rst_pin_s;
    logic       ext_sel_n_s;
    logic       strobe_n_s;
    logic       parallel_s;
    logic       rx_s;

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pin_meta <= 5'h16;
            pin_sync <= 5'h16;
        end
        else
        begin
            pin_meta <= {serial_rx_pin, parallel_mode_pin, program_store_strobe_n,
                         external_fetch_select_n, reset_pin};
            pin_sync <= pin_meta;
        end
    end

    assign rst_pin_s   = pin_sync[0];
    assign ext_sel_n_s = pin_sync[1];
    assign strobe_n_s  = pin_sync[2];
    assign parallel_s  = pin_sync[3];
    assign rx_s        = pin_sync[4];

    ////////////////////////////////////////////////////////////////////////
    // Persistent state and reset-time captures
    logic [2:0] lock_bits;
    logic [2:0] next_lock_bits;
    logic [7:0] option_byte;
    logic [7:0] next_option_byte;
    logic [2:0] next_size_select;
    logic [1:0] captured;
    logic       ea_latched;
    logic       next_ea_latched;
    logic       next_wdt_enable;
    logic       ta_open;

    always_comb
    begin
        if (!lock_bits[2])
            lock_level = PMS_LEVEL_4;
        else if (!lock_bits[1])
            lock_level = PMS_LEVEL_3;
        else if (!lock_bits[0])
            lock_level = PMS_LEVEL_2;
        else
            lock_level = PMS_LEVEL_1;
    end

    logic lvl2_up;
    logic lvl3_up;
    logic lvl4;
    logic prog_mode;

    assign lvl2_up = (lock_level != PMS_LEVEL_1);
    assign lvl3_up = (lock_level == PMS_LEVEL_3) || (lock_level == PMS_LEVEL_4);
    assign lvl4    = (lock_level == PMS_LEVEL_4);

    assign loader_mode = rst_pin_s && !ext_sel_n_s && !strobe_n_s;
    assign prog_mode   = loader_mode || parallel_s;

    pms_timed_access u_timed_access
    (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .ta_write (ta_write),
        .ta_wdata (ta_wdata),
        .ta_open  (ta_open)
    );

    pms_autobaud u_autobaud
    (
        .core_clk     (core_clk),
        .reset_n      (reset_n),
        .enable       (loader_mode),
        .rx_level     (rx_s),
        .baud_divisor (baud_divisor),
        .baud_locked  (baud_locked)
    );

    always_comb
    begin
        next_size_select = program_size_select;
        next_ea_latched  = ea_latched;
        next_wdt_enable  = watchdog_reset_enable;
        if (size_write && ta_open)
            next_size_select = size_wdata;
        if (captured == 2'h2)
        begin
            next_ea_latched = ext_sel_n_s;
            next_wdt_enable = !option_byte[OPT_WDT_BIT];
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            program_size_select   <= SIZE_SEL_RESET;
            captured              <= 2'h0;
            ea_latched            <= 1'b1;
            watchdog_reset_enable <= 1'b0;
        end
        else
        begin
            program_size_select   <= next_size_select;
            captured              <= captured + 2'(captured != 2'h3);
            ea_latched            <= next_ea_latched;
            watchdog_reset_enable <= next_wdt_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fetch routing, evaluated against the live size limit
    logic [16:0] size_limit;
    logic        ea_eff_n;
    logic        fetch_in_range;
    logic        table_in_range;

    assign size_limit     = SIZE_TABLE[program_size_select];
    assign ea_eff_n       = lvl2_up ? ea_latched : ext_sel_n_s;
    assign fetch_in_range = ({1'b0, fetch_addr} < size_limit);
    assign table_in_range = ({1'b0, table_read_addr} < size_limit);

    always_comb
    begin
        fetch_internal   = 1'b0;
        fetch_external   = 1'b0;
        fetch_loader_rom = 1'b0;
        fetch_refused    = 1'b0;
        if (fetch_valid)
        begin
            if (loader_mode)
                fetch_loader_rom = 1'b1;
            else if (ea_eff_n && fetch_in_range)
                fetch_internal = 1'b1;
            else if (lvl4)
                fetch_refused = 1'b1;
            else
                fetch_external = 1'b1;
        end
    end

    always_comb
    begin
        table_read_internal = 1'b0;
        table_read_blocked  = 1'b0;
        if (table_read_valid && ea_eff_n && table_in_range)
        begin
            if (table_read_from_external && lvl2_up)
                table_read_blocked = 1'b1;
            else
                table_read_internal = 1'b1;
        end
    end

    always_comb
    begin
        data_move_sram_allowed = 1'b0;
        data_move_blocked      = 1'b0;
        if (data_move_valid && data_move_to_sram)
        begin
            if (data_move_from_external && lvl3_up)
                data_move_blocked = 1'b1;
            else
                data_move_sram_allowed = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Programming command port, answered one cycle after the request
    logic [7:0] next_rdata;
    logic       next_done;
    logic       next_refused;
    logic       next_write_grant;
    logic       next_verify_grant;
    logic       next_verify_enc;

    always_comb
    begin
        next_rdata        = prog_rdata;
        next_done         = 1'b0;
        next_refused      = 1'b0;
        next_write_grant  = 1'b0;
        next_verify_grant = 1'b0;
        next_verify_enc   = 1'b0;
        next_lock_bits    = lock_bits;
        next_option_byte  = option_byte;
        if (prog_valid)
        begin
            if (!prog_mode)
                next_refused = 1'b1;
            else
            begin
                next_done = 1'b1;
                case (prog_cmd)
                    PMS_CMD_READ_INFO:
                    begin
                        case (prog_addr)
                            OPT_ADDR:        next_rdata = option_byte | OPT_UNDEF_MASK;
                            SIG_MAKER_ADDR:  next_rdata = MAKER_ID;
                            SIG_DEVICE_ADDR: next_rdata = DEVICE_ID;
                            SIG_EXT_ADDR:    next_rdata = EXT_ID;
                            default:         next_rdata = INFO_BLANK;
                        endcase
                    end
                    PMS_CMD_VERIFY_OPT:
                        next_rdata = option_byte | OPT_UNDEF_MASK;
                    PMS_CMD_WRITE_OPT:
                        next_option_byte = option_byte & prog_wdata;
                    PMS_CMD_ERASE_OPT:
                        next_option_byte = OPT_ERASED;
                    PMS_CMD_PROG_LOCK:
                        next_lock_bits = lock_bits & prog_wdata[2:0];
                    PMS_CMD_READ_LOCK:
                        next_rdata = {5'h1F, lock_bits};
                    PMS_CMD_MASS_ERASE:
                    begin
                        next_lock_bits   = LOCK_ERASED;
                        next_option_byte = OPT_ERASED;
                    end
                    PMS_CMD_PROG_CODE:
                    begin
                        if (lvl2_up)
                        begin
                            next_done    = 1'b0;
                            next_refused = 1'b1;
                        end
                        else
                            next_write_grant = 1'b1;
                    end
                    PMS_CMD_VERIFY_CODE:
                    begin
                        if (lvl3_up)
                        begin
                            next_done    = 1'b0;
                            next_refused = 1'b1;
                        end
                        else
                        begin
                            next_verify_grant = 1'b1;
                            next_verify_enc   = encryption_programmed;
                        end
                    end
                    default:
                    begin
                        next_done    = 1'b0;
                        next_refused = 1'b1;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prog_rdata        <= 8'h00;
            prog_done         <= 1'b0;
            prog_refused      <= 1'b0;
            flash_write_grant <= 1'b0;
            verify_grant      <= 1'b0;
            verify_encrypted  <= 1'b0;
            lock_bits         <= LOCK_ERASED;
            option_byte       <= OPT_ERASED;
        end
        else
        begin
            prog_rdata        <= next_rdata;
            prog_done         <= next_done;
            prog_refused      <= next_refused;
            flash_write_grant <= next_write_grant;
            verify_grant      <= next_verify_grant;
            verify_encrypted  <= next_verify_enc;
            lock_bits         <= next_lock_bits;
            option_byte       <= next_option_byte;
        end
    end

endmodule // pms_program_memory_security

// ==== logic/pms_pkg.sv ====
// Shared constants and types for the program-memory security block
package pms_pkg;

    // Program address width and internal size limits
    localparam int             ADDR_W          = 16;
    localparam logic [16:0]    SIZE_0K         = 17'h00000;
    localparam logic [16:0]    SIZE_1K         = 17'h00400;
    localparam logic [16:0]    SIZE_2K         = 17'h00800;
    localparam logic [16:0]    SIZE_4K         = 17'h01000;
    localparam logic [16:0]    SIZE_8K         = 17'h02000;
    localparam logic [16:0]    SIZE_16K        = 17'h04000;
    localparam logic [2:0]     SIZE_SEL_RESET  = 3'h5;

    // Program-size select code to internal limit
    localparam logic [16:0]    SIZE_TABLE [8]  = '{SIZE_0K, SIZE_1K, SIZE_2K, SIZE_4K,
                                                   SIZE_8K, SIZE_16K, SIZE_16K, SIZE_16K};

    // Timed-access unlock
    localparam logic [7:0]     TA_KEY_FIRST    = 8'hAA;
    localparam logic [7:0]     TA_KEY_SECOND   = 8'h55;
    localparam logic [2:0]     TA_OPEN_CYCLES  = 3'h4;

    // Information space addresses
    localparam logic [7:0]     OPT_ADDR        = 8'hFC;
    localparam logic [7:0]     SIG_MAKER_ADDR  = 8'h30;
    localparam logic [7:0]     SIG_DEVICE_ADDR = 8'h31;
    localparam logic [7:0]     SIG_EXT_ADDR    = 8'h60;
    localparam logic [7:0]     INFO_BLANK      = 8'hFF;

    // Option byte
    localparam logic [7:0]     OPT_ERASED      = 8'hFF;
    localparam int             OPT_WDT_BIT     = 3;
    localparam logic [7:0]     OPT_UNDEF_MASK  = 8'hF7;

    // Lock bits, bit 0 first, bit 2 third
    localparam logic [2:0]     LOCK_ERASED     = 3'h7;

    // Auto-baud counter width
    localparam int             BAUD_W          = 16;

    typedef enum logic [1:0]
    {
        PMS_LEVEL_1 = 2'b00,
        PMS_LEVEL_2 = 2'b01,
        PMS_LEVEL_3 = 2'b10,
        PMS_LEVEL_4 = 2'b11
    } pms_level_t;

    typedef enum logic [3:0]
    {
        PMS_CMD_READ_INFO   = 4'h0,
        PMS_CMD_VERIFY_OPT  = 4'h1,
        PMS_CMD_WRITE_OPT   = 4'h2,
        PMS_CMD_ERASE_OPT   = 4'h3,
        PMS_CMD_PROG_LOCK   = 4'h4,
        PMS_CMD_READ_LOCK   = 4'h5,
        PMS_CMD_MASS_ERASE  = 4'h6,
        PMS_CMD_PROG_CODE   = 4'h7,
        PMS_CMD_VERIFY_CODE = 4'h8
    } pms_cmd_t;

endpackage

// ==== logic/pms_timed_access.sv ====
// Timed-access unlock sequencer
`timescale 1ns/100ps
module pms_timed_access
    import pms_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic        ta_write,
    input  wire logic [7:0]  ta_wdata,
    output logic             ta_open
);

    typedef enum logic [1:0]
    {
        PMS_TA_IDLE  = 2'b00,
        PMS_TA_ARMED = 2'b01,
        PMS_TA_OPEN  = 2'b10
    } pms_ta_state_t;

    pms_ta_state_t state;
    pms_ta_state_t next_state;
    logic [2:0]    count;
    logic [2:0]    next_count;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_state = state;
        next_count = count;
        case (state)
            PMS_TA_IDLE:
            begin
                if (ta_write && ta_wdata == TA_KEY_FIRST)
                begin
                    next_state = PMS_TA_ARMED;
                    next_count = TA_OPEN_CYCLES;
                end
            end
            PMS_TA_ARMED:
            begin
                next_count = count - 3'h1;
                if (ta_write && ta_wdata == TA_KEY_SECOND)
                begin
                    next_state = PMS_TA_OPEN;
                    next_count = TA_OPEN_CYCLES;
                end
                else if (ta_write || count == 3'h1)
                    next_state = PMS_TA_IDLE;
            end
            PMS_TA_OPEN:
            begin
                next_count = count - 3'h1;
                if (count == 3'h1)
                    next_state = PMS_TA_IDLE;
            end
            default:
            begin
                next_state = PMS_TA_IDLE;
                next_count = 3'h0;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= PMS_TA_IDLE;
            count <= 3'h0;
        end
        else
        begin
            state <= next_state;
            count <= next_count;
        end
    end

    assign ta_open = (state == PMS_TA_OPEN);

endmodule // pms_timed_access

// ==== logic/pms_autobaud.sv ====
// Loader auto-baud: measures the host start bit in core clocks
`timescale 1ns/100ps
module pms_autobaud
    import pms_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              reset_n,
    input  wire logic              enable,
    input  wire logic              rx_level,
    output logic [BAUD_W-1:0]      baud_divisor,
    output logic                   baud_locked
);

    typedef enum logic [1:0]
    {
        PMS_AB_WAIT    = 2'b00,
        PMS_AB_MEASURE = 2'b01,
        PMS_AB_LOCKED  = 2'b10
    } pms_ab_state_t;

    pms_ab_state_t     state;
    pms_ab_state_t     next_state;
    logic [BAUD_W-1:0] count;
    logic [BAUD_W-1:0] next_count;
    logic [BAUD_W-1:0] next_divisor;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_state   = state;
        next_count   = count;
        next_divisor = baud_divisor;
        case (state)
            PMS_AB_WAIT:
            begin
                next_count = '0;
                if (enable && !rx_level)
                begin
                    next_state = PMS_AB_MEASURE;
                    next_count = {{(BAUD_W-1){1'b0}}, 1'b1};
                end
            end
            PMS_AB_MEASURE:
            begin
                // Start bit ends at the first high level
                if (!enable)
                    next_state = PMS_AB_WAIT;
                else if (rx_level)
                begin
                    next_state   = PMS_AB_LOCKED;
                    next_divisor = count;
                end
                else if (count != '1)
                    next_count = count + {{(BAUD_W-1){1'b0}}, 1'b1};
            end
            PMS_AB_LOCKED:
            begin
                if (!enable)
                    next_state = PMS_AB_WAIT;
            end
            default:
            begin
                next_state = PMS_AB_WAIT;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state        <= PMS_AB_WAIT;
            count        <= '0;
            baud_divisor <= '0;
        end
        else
        begin
            state        <= next_state;
            count        <= next_count;
            baud_divisor <= next_divisor;
        end
    end

    assign baud_locked = (state == PMS_AB_LOCKED);

endmodule // pms_autobaud

// ==== testbench/pms_security_monitor.sv ====
// Port checker for program-memory security
`timescale 1ns/100ps
module pms_security_monitor
    import pms_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        reset_n,
    input wire logic        prog_valid,
    input wire logic [3:0]  prog_cmd,
    input wire logic        prog_done,
    input wire logic        prog_refused,
    input wire logic        verify_grant,
    input wire logic        verify_encrypted,
    input wire logic        encryption_programmed,
    input wire pms_level_t  lock_level,
    input wire logic        fetch_valid,
    input wire logic [15:0] fetch_addr,
    input wire logic        fetch_internal,
    input wire logic        fetch_external,
    input wire logic [2:0]  program_size_select,
    input wire logic        loader_mode,
    input wire logic        size_write,
    input wire logic        table_read_valid,
    input wire logic        table_read_from_external,
    input wire logic        table_read_internal
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////
    sequence code_req;
        prog_valid && prog_cmd == PMS_CMD_PROG_CODE;
    endsequence
    answer_once_a: assert property (prog_valid |=> prog_done != prog_refused)
        else $error("no single answer");
    code_lock_a: assert property (code_req ##0 lock_level != PMS_LEVEL_1 |=> prog_refused)
        else $error("code write at lock");
    verify_lock_a: assert property (prog_valid && prog_cmd == PMS_CMD_VERIFY_CODE
        && lock_level[1] |=> !verify_grant) else $error("verify at lock");
    enc_verify_a: assert property (verify_encrypted |-> verify_grant
        && $past(encryption_programmed)) else $error("bad encrypt");
    size_limit_a: assert property (fetch_valid && !loader_mode
        && fetch_addr >= SIZE_TABLE[program_size_select] |-> !fetch_internal)
        else $error("internal above limit");
    size_guard_a: assert property ($changed(program_size_select) |-> $past(size_write))
        else $error("size changed alone");
    ext_exec_a: assert property (fetch_valid && lock_level == PMS_LEVEL_4 |-> !fetch_external)
        else $error("external run at level 4");
    table_guard_a: assert property (table_read_valid && table_read_from_external
        && lock_level != PMS_LEVEL_1 |-> !table_read_internal) else $error("table read leak");
endmodule // pms_security_monitor

// ==== testbench/pms_host_model.sv ====
// Host model: loader entry pins and a start bit
`timescale 1ns/100ps
module pms_host_model
(
    input wire logic       core_clk,
    input wire logic       enter,
    input wire logic [7:0] bit_len,
    output logic           reset_pin,
    output logic           external_fetch_select_n,
    output logic           program_store_strobe_n,
    output logic           serial_rx_pin
);
    logic [7:0] cnt = 8'h00;
    assign reset_pin = enter;
    assign external_fetch_select_n = !enter;
    assign program_store_strobe_n = !enter;
    always @(negedge core_clk)
    begin
        cnt <= enter ? cnt + 8'(cnt != 8'hFF) : 8'h00;
        serial_rx_pin <= !(enter && cnt >= 8'h04 && cnt < 8'h04 + bit_len);
    end
endmodule // pms_host_model

// ==== testbench/program_memory_security_tb_top.sv ====
// Testbench for program-memory security
`timescale 1ns/100ps
module program_memory_security_tb_top
    import pms_pkg::*;
;
    logic core_clk = 0, reset_n = 0, enter = 0, parallel_mode_pin = 0, prog_valid = 0;
    logic fetch_valid = 0, table_read_valid = 0, table_read_from_external = 1;
    logic data_move_valid = 0, data_move_from_external = 1, data_move_to_sram = 1;
    logic ta_write = 0, size_write = 0, encryption_programmed = 1;
    logic [15:0] fetch_addr = 0, table_read_addr = 0, baud_divisor;
    logic [7:0] ta_wdata = 0, prog_addr = 0, prog_wdata = 0, bit_len = 8, prog_rdata;
    logic [3:0] prog_cmd = 0;
    logic [2:0] size_wdata = 0, program_size_select;
    logic reset_pin, external_fetch_select_n, program_store_strobe_n, serial_rx_pin;
    logic fetch_internal, fetch_external, fetch_loader_rom, fetch_refused, baud_locked;
    logic table_read_internal, table_read_blocked, data_move_sram_allowed, data_move_blocked;
    logic prog_done, prog_refused, flash_write_grant, verify_grant, verify_encrypted;
    logic loader_mode, watchdog_reset_enable;
    pms_level_t lock_level;
    int fails = 0, n_checks = 0, i;
    logic [31:0] rs = 32'hD8C2;
    pms_program_memory_security dut (.*);
    pms_host_model host (.*);
    always #50 core_clk = !core_clk;
    ////////////////////////////////////////
    function automatic logic [31:0] lf(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [15:0] g, e);
        n_checks++;
        if (g !== e)
        begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic prog(input logic [3:0] c, input logic [7:0] a, w, input logic rf,
                        input logic [7:0] er);
        prog_valid = 1;
        prog_cmd = c;
        prog_addr = a;
        prog_wdata = w;
        @(negedge core_clk);
        prog_valid = 0;
        chk(prog_refused, rf);
        if (!rf && (c < 2 || c == 5))
            chk(prog_rdata, er);
        @(negedge core_clk);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////
    initial
    begin
        repeat (20) @(negedge core_clk);
        reset_n = 1;
        repeat (4) @(negedge core_clk);
        chk(program_size_select, SIZE_SEL_RESET);
        chk(watchdog_reset_enable, 0);
        fetch_valid = 1;
        table_read_valid = 1;
        for (i = 0; i < 10; i++)
        begin
            rs = lf(rs);
            fetch_addr = rs[15:0] & 16'h3FFF;
            table_read_addr = fetch_addr;
            #1;
            chk(fetch_internal, 1);
            chk(table_read_internal, 1);
            @(negedge core_clk);
        end
        size_write = 1;
        size_wdata = 3'h3;
        @(negedge core_clk);
        size_write = 0;
        @(negedge core_clk);
        chk(program_size_select, SIZE_SEL_RESET);
        for (i = 0; i < 8; i++)
        begin
            ta_write = 1;
            ta_wdata = TA_KEY_FIRST;
            @(negedge core_clk);
            ta_wdata = TA_KEY_SECOND;
            @(negedge core_clk);
            ta_write = 0;
            size_wdata = 3'(i + 4);
            size_write = 1;
            @(negedge core_clk);
            size_write = 0;
            rs = lf(rs);
            fetch_addr = rs[15:0];
            #1;
            chk(program_size_select, size_wdata);
            chk(fetch_internal, fetch_addr < SIZE_TABLE[size_wdata]);
            repeat (3) @(negedge core_clk);
        end
        $display("size test done");
        fetch_valid = 0;
        prog(PMS_CMD_READ_INFO, SIG_MAKER_ADDR, 0, 1, 0);
        bit_len = 8'd6 + 8'(rs[3:0]);
        enter = 1;
        for (i = 0; i < 100 && baud_locked !== 1; i++)
            @(negedge core_clk);
        chk(baud_locked, 1);
        if (baud_locked !== 1)
            complete_run;
        chk(baud_divisor, bit_len);
        prog(PMS_CMD_READ_INFO, SIG_MAKER_ADDR, 0, 0, 8'h5A);
        prog(PMS_CMD_READ_INFO, SIG_DEVICE_ADDR, 0, 0, 8'h3C);
        prog(PMS_CMD_READ_INFO, SIG_EXT_ADDR, 0, 0, 8'h07);
        prog(PMS_CMD_WRITE_OPT, OPT_ADDR, 8'h00, 0, 0);
        prog(PMS_CMD_READ_INFO, OPT_ADDR, 0, 0, OPT_UNDEF_MASK);
        prog(PMS_CMD_VERIFY_OPT, OPT_ADDR, 0, 0, OPT_UNDEF_MASK);
        prog(PMS_CMD_ERASE_OPT, OPT_ADDR, 0, 0, 0);
        prog(PMS_CMD_READ_INFO, OPT_ADDR, 0, 0, OPT_ERASED);
        prog(PMS_CMD_VERIFY_CODE, 0, 0, 0, 0);
        prog(PMS_CMD_PROG_LOCK, 0, 8'h06, 0, 0);
        chk(lock_level, PMS_LEVEL_2);
        prog(PMS_CMD_PROG_CODE, 0, 0, 1, 0);
        prog(PMS_CMD_PROG_LOCK, 0, 8'h05, 0, 0);
        chk(lock_level, PMS_LEVEL_3);
        prog(PMS_CMD_VERIFY_CODE, 0, 0, 1, 0);
        prog(PMS_CMD_PROG_LOCK, 0, 8'h03, 0, 0);
        prog(PMS_CMD_READ_LOCK, 0, 0, 0, 8'hF8);
        chk(lock_level, PMS_LEVEL_4);
        $display("loader test done");
        enter = 0;
        repeat (4) @(negedge core_clk);
        fetch_valid = 1;
        fetch_addr = 16'h8000;
        table_read_addr = 16'h0100;
        data_move_valid = 1;
        #1;
        chk(fetch_refused, 1);
        chk(table_read_blocked, 1);
        chk(data_move_blocked, 1);
        $display("lock test done");
        complete_run;
    end
endmodule // program_memory_security_tb_top
bind pms_program_memory_security pms_security_monitor mon (.*);
